// ===== rtl/adc_cfg_consts.vh
// Constants of the converter configuration port: bus map, fields, resets, timing.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef ADC_CFG_CONSTS_VH
`define ADC_CFG_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Bus register byte offsets
`define OFS_STATUS      8'h00
`define OFS_CONTROL     8'h04
`define OFS_INDEX       8'h08
`define OFS_DATA        8'h0c
`define OFS_WORDS       8'h10

// Bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Control fields and reset values
`define CTRL_PORT_EN    0
`define CTRL_RESET      1'h1
`define INDEX_RESET     8'h00

// Status fields
`define ST_PARALLEL     0
`define ST_EXT_REF      1
`define ST_TWOS         2
`define ST_CMOS         3
`define ST_PDOWN        4
`define ST_STBY_B       5
`define ST_NS_A         6
`define ST_NS_B         7

////////////////////////////////////////////////////////////////////////////////
// Serial word layout
`define WORD_BITS       16
`define CNT_LAST        4'hf
`define SW_RESET_ADDR   8'h00
`define SW_RESET_BIT    7
`define REG_DEFAULT     8'h00
`define REG_COUNT       256

// Multi-level pin codes from the level comparator
`define LVL_GND         2'h0
`define LVL_3_8         2'h1
`define LVL_5_8         2'h2
`define LVL_FULL        2'h3

// Mode pin patterns (pin 1, pin 2, pin 3)
`define MODE_NORMAL     3'h0
`define MODE_NS_B       3'h1
`define MODE_NS_A       3'h2
`define MODE_NS_AB      3'h3
`define MODE_PDOWN      3'h4
`define MODE_STBY_B     3'h5

////////////////////////////////////////////////////////////////////////////////
// Timing
`define CLK_PERIOD_NS   20
`define PAR_HOLD_NS     1000
`define PAR_HOLD_CYC    ((`PAR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_STAGES     3

`endif

// ===== rtl/pin_sync.v
// Pin synchroniser bank: three flip-flops plus a level register per bit, a change is accepted once
// the second and third stages agree.
// Assumes inputs are asynchronous to CLK and stay stable for three CLK cycles.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // Asynchronous pins in, filtered levels out
   input  wire [W-1:0] pin_in,
   output wire [W-1:0] level_out
);

   reg [W-1:0] s1_ff;
   reg [W-1:0] s2_ff;
   reg [W-1:0] s3_ff;
   reg [W-1:0] lvl_ff;

   assign level_out = lvl_ff;

   ////////////////////////////////////////////////////////////////////////////
   // The first stage feeds only the second; agreement check uses stages 2 and 3
   genvar gi;
   generate
      for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_ff[gi]  <= 1'b0;
               s2_ff[gi]  <= 1'b0;
               s3_ff[gi]  <= 1'b0;
               lvl_ff[gi] <= 1'b0;
            end else begin
               s1_ff[gi] <= pin_in[gi];
               s2_ff[gi] <= s1_ff[gi];
               s3_ff[gi] <= s2_ff[gi];
               if (s2_ff[gi] == s3_ff[gi]) begin
                  lvl_ff[gi] <= s3_ff[gi];
               end
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ===== rtl/adc_config_serial_port.v
// Configuration logic of a dual-channel converter: mode selection from the
// reset pin, parallel pin decode, three-wire serial register writes, and an
// AXI4-Lite window onto the configuration registers.
// Assumes pins are asynchronous to CLK and that multi-level pins arrive as a
// two-bit level code from an external comparator.
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg_consts.vh"

module adc_config_serial_port (
   // Clock and reset
   input  wire        CLK,
   input  wire        RST_N,
   // AXI4-Lite write address
   input  wire [7:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output wire        S_AXI_AWREADY,
   // AXI4-Lite write data
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output wire        S_AXI_WREADY,
   // AXI4-Lite write response
   output wire [1:0]  S_AXI_BRESP,
   output wire        S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   // AXI4-Lite read address
   input  wire [7:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output wire        S_AXI_ARREADY,
   // AXI4-Lite read data
   output wire [31:0] S_AXI_RDATA,
   output wire [1:0]  S_AXI_RRESP,
   output wire        S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   // Configuration pins
   input  wire        RESET_PIN,
   input  wire        SERIAL_SELECT_N,
   input  wire        SHIFT_CLK,
   input  wire        SERIAL_DATA_IN,
   input  wire        MODE_PIN_1,
   input  wire        MODE_PIN_2,
   input  wire        MODE_PIN_3,
   input  wire [1:0]  SELECT_LEVEL,
   input  wire [1:0]  SHIFT_CLK_LEVEL,
   // Decoded configuration
   output wire        PARALLEL_MODE,
   output wire        EXT_REF,
   output wire        TWOS_COMP,
   output wire        CMOS_OUT,
   output wire        POWER_DOWN,
   output wire        STANDBY_B,
   output wire        NOISE_SHAPE_ON_A,
   output wire        NOISE_SHAPE_ON_B
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   wire [10:0] pins_lvl;
   wire        rst_pin;
   wire        sel_n;
   wire        sclk;
   wire        serial_data_in;
   wire [2:0]  mode_pins;
   wire [1:0]  sel_level;
   wire [1:0]  sclk_level;

   pin_sync #(
      .W         (11)
   ) u_sync (
      .clk       (CLK),
      .rst_n     (RST_N),
      .pin_in    ({RESET_PIN, SERIAL_SELECT_N, SHIFT_CLK, SERIAL_DATA_IN,
                   MODE_PIN_1, MODE_PIN_2, MODE_PIN_3,
                   SELECT_LEVEL, SHIFT_CLK_LEVEL}),
      .level_out (pins_lvl)
   );

   assign rst_pin    = pins_lvl[10];
   assign sel_n      = pins_lvl[9];
   assign sclk       = pins_lvl[8];
   assign serial_data_in      = pins_lvl[7];
   assign mode_pins  = pins_lvl[6:4];
   assign sel_level  = pins_lvl[3:2];
   assign sclk_level = pins_lvl[1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Reset pin: pulse versus permanent high
   reg        rst_pin_d_ff;
   reg [6:0]  hold_cnt_ff;
   reg        parallel_ff;
   wire       hw_reg_reset;
   wire       hold_done;

   assign hw_reg_reset = rst_pin & ~rst_pin_d_ff;
   assign hold_done    = ({25'h0, hold_cnt_ff} == `PAR_HOLD_CYC);

   // A high level held past the hold time enters parallel mode until the pin falls
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_pin_d_ff <= 1'b0;
         hold_cnt_ff  <= 7'h00;
         parallel_ff  <= 1'b0;
      end else begin
         rst_pin_d_ff <= rst_pin;
         if (!rst_pin) begin
            hold_cnt_ff <= 7'h00;
            parallel_ff <= 1'b0;
         end else if (!hold_done) begin
            hold_cnt_ff <= hold_cnt_ff + 7'h01;
         end else begin
            parallel_ff <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial shift port
   reg        sclk_d_ff;
   reg [14:0] shift_ff;
   reg [3:0]  bit_cnt_ff;
   reg        port_en_ff;
   reg [15:0] words_ff;
   wire       sclk_fall;
   wire       ser_active;
   wire       ser_commit;
   wire [15:0] ser_word;

   assign sclk_fall  = sclk_d_ff & ~sclk;
   assign ser_active = ~sel_n & ~parallel_ff & ~rst_pin & port_en_ff;
   assign ser_commit = ser_active & sclk_fall & (bit_cnt_ff == `CNT_LAST);
   // First bit ends up as the top bit
   assign ser_word   = {shift_ff, serial_data_in};

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sclk_d_ff  <= 1'b0;
         shift_ff   <= 15'h0000;
         bit_cnt_ff <= 4'h0;
      end else begin
         sclk_d_ff <= sclk;
         if (!ser_active) begin
            bit_cnt_ff <= 4'h0;
         end else if (sclk_fall) begin
            shift_ff   <= ser_word[14:0];
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration register array
   reg [7:0]  regs_ff [0:`REG_COUNT-1];
   reg [7:0]  index_ff;
   reg [31:0] wdata_ff;
   reg        wr_en;
   reg [7:0]  wr_addr;
   reg [7:0]  wr_data;
   wire       sw_reg_reset;
   wire       clr_regs;
   wire       bus_data_wr;
   integer    i;

   // Serial writes win; a bus write to the data window waits one cycle
   always @* begin
      wr_en   = 1'b0;
      wr_addr = 8'h00;
      wr_data = 8'h00;
      if (ser_commit) begin
         wr_en   = 1'b1;
         wr_addr = ser_word[15:8];
         wr_data = ser_word[7:0];
      end else if (bus_data_wr) begin
         wr_en   = 1'b1;
         wr_addr = index_ff;
         wr_data = wdata_ff[7:0];
      end
   end

   assign sw_reg_reset = wr_en & (wr_addr == `SW_RESET_ADDR) & wr_data[`SW_RESET_BIT];
   assign clr_regs     = hw_reg_reset | sw_reg_reset;

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (i = 0; i < `REG_COUNT; i = i + 1) begin
            regs_ff[i] <= `REG_DEFAULT;
         end
      end else if (clr_regs) begin
         for (i = 0; i < `REG_COUNT; i = i + 1) begin
            regs_ff[i] <= `REG_DEFAULT;
         end
      end else if (wr_en) begin
         regs_ff[wr_addr] <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin decode into registered outputs
   reg        ext_ref_ff;
   reg        twos_ff;
   reg        cmos_ff;
   reg        pdown_ff;
   reg        stby_b_ff;
   reg        ns_a_ff;
   reg        ns_b_ff;
   reg        parallel_out_ff;

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ext_ref_ff      <= 1'b0;
         twos_ff         <= 1'b0;
         cmos_ff         <= 1'b0;
         pdown_ff        <= 1'b0;
         stby_b_ff       <= 1'b0;
         ns_a_ff         <= 1'b0;
         ns_b_ff         <= 1'b0;
         parallel_out_ff <= 1'b0;
      end else begin
         parallel_out_ff <= parallel_ff;
         if (parallel_ff) begin
            ext_ref_ff <= (sclk_level == `LVL_3_8) | (sclk_level == `LVL_5_8);
            twos_ff    <= (sel_level == `LVL_3_8) | (sel_level == `LVL_5_8);
            cmos_ff    <= (sel_level == `LVL_5_8) | (sel_level == `LVL_FULL);
         end else begin
            // Serial modes leave reference and format at their defaults
            ext_ref_ff <= 1'b0;
            twos_ff    <= 1'b0;
            cmos_ff    <= 1'b0;
         end
         pdown_ff  <= (mode_pins == `MODE_PDOWN);
         stby_b_ff <= (mode_pins == `MODE_STBY_B);
         ns_a_ff   <= (mode_pins == `MODE_NS_A) | (mode_pins == `MODE_NS_AB);
         ns_b_ff   <= (mode_pins == `MODE_NS_B) | (mode_pins == `MODE_NS_AB);
      end
   end

   assign PARALLEL_MODE    = parallel_out_ff;
   assign EXT_REF          = ext_ref_ff;
   assign TWOS_COMP        = twos_ff;
   assign CMOS_OUT         = cmos_ff;
   assign POWER_DOWN       = pdown_ff;
   assign STANDBY_B        = stby_b_ff;
   assign NOISE_SHAPE_ON_A = ns_a_ff;
   assign NOISE_SHAPE_ON_B = ns_b_ff;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   reg        aw_held_ff;
   reg [7:0]  awaddr_ff;
   reg        awready_ff;
   reg        w_held_ff;
   reg [3:0]  wstrb_ff;
   reg        wready_ff;
   reg        bvalid_ff;
   reg [1:0]  bresp_ff;
   wire       aw_take;
   wire       w_take;
   wire       do_wr;
   wire       nxt_aw_held;
   wire       nxt_w_held;
   wire       nxt_bvalid;
   wire       wr_mapped;

   assign aw_take     = S_AXI_AWVALID & awready_ff;
   assign w_take      = S_AXI_WVALID & wready_ff;
   assign do_wr       = aw_held_ff & w_held_ff & ~bvalid_ff & ~ser_commit;
   assign nxt_aw_held = do_wr ? 1'b0 : (aw_held_ff | aw_take);
   assign nxt_w_held  = do_wr ? 1'b0 : (w_held_ff | w_take);
   assign nxt_bvalid  = do_wr | (bvalid_ff & ~S_AXI_BREADY);
   assign wr_mapped   = (awaddr_ff == `OFS_STATUS) | (awaddr_ff == `OFS_CONTROL) |
                        (awaddr_ff == `OFS_INDEX) | (awaddr_ff == `OFS_DATA) |
                        (awaddr_ff == `OFS_WORDS);
   assign bus_data_wr = do_wr & (awaddr_ff == `OFS_DATA) & wstrb_ff[0];

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_held_ff <= 1'b0;
         awaddr_ff  <= 8'h00;
         awready_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `RESP_OKAY;
         port_en_ff <= `CTRL_RESET;
         index_ff   <= `INDEX_RESET;
      end else begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff  <= nxt_w_held;
         bvalid_ff  <= nxt_bvalid;
         awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
         wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
         if (aw_take) begin
            awaddr_ff <= S_AXI_AWADDR;
         end
         if (w_take) begin
            wdata_ff <= S_AXI_WDATA;
            wstrb_ff <= S_AXI_WSTRB;
         end
         if (do_wr) begin
            bresp_ff <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            if (awaddr_ff == `OFS_CONTROL && wstrb_ff[0]) begin
               port_en_ff <= wdata_ff[`CTRL_PORT_EN];
            end
            if (awaddr_ff == `OFS_INDEX && wstrb_ff[0]) begin
               index_ff <= wdata_ff[7:0];
            end
         end
      end
   end

   // Committed word counter, wraps; lets software see serial traffic
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         words_ff <= 16'h0000;
      end else if (ser_commit) begin
         words_ff <= words_ff + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   reg        arready_ff;
   reg        rvalid_ff;
   reg [31:0] rdata_ff;
   reg [1:0]  rresp_ff;
   reg [31:0] rd_mux;
   reg [1:0]  rd_resp;
   wire       ar_take;
   wire       nxt_rvalid;

   assign ar_take    = S_AXI_ARVALID & arready_ff;
   assign nxt_rvalid = ar_take | (rvalid_ff & ~S_AXI_RREADY);

   always @* begin
      rd_mux  = 32'h0000_0000;
      rd_resp = `RESP_OKAY;
      case (S_AXI_ARADDR)
         `OFS_STATUS: begin
            rd_mux[`ST_PARALLEL] = parallel_out_ff;
            rd_mux[`ST_EXT_REF]  = ext_ref_ff;
            rd_mux[`ST_TWOS]     = twos_ff;
            rd_mux[`ST_CMOS]     = cmos_ff;
            rd_mux[`ST_PDOWN]    = pdown_ff;
            rd_mux[`ST_STBY_B]   = stby_b_ff;
            rd_mux[`ST_NS_A]     = ns_a_ff;
            rd_mux[`ST_NS_B]     = ns_b_ff;
         end
         `OFS_CONTROL: begin
            rd_mux[`CTRL_PORT_EN] = port_en_ff;
         end
         `OFS_INDEX: begin
            rd_mux[7:0] = index_ff;
         end
         `OFS_DATA: begin
            rd_mux[7:0] = regs_ff[index_ff];
         end
         `OFS_WORDS: begin
            rd_mux[15:0] = words_ff;
         end
         default: begin
            rd_resp = `RESP_SLVERR;
         end
      endcase
   end

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= `RESP_OKAY;
      end else begin
         rvalid_ff  <= nxt_rvalid;
         arready_ff <= ~nxt_rvalid;
         if (ar_take) begin
            rdata_ff <= rd_mux;
            rresp_ff <= rd_resp;
         end
      end
   end

   assign S_AXI_AWREADY = awready_ff;
   assign S_AXI_WREADY  = wready_ff;
   assign S_AXI_BVALID  = bvalid_ff;
   assign S_AXI_BRESP   = bresp_ff;
   assign S_AXI_ARREADY = arready_ff;
   assign S_AXI_RVALID  = rvalid_ff;
   assign S_AXI_RDATA   = rdata_ff;
   assign S_AXI_RRESP   = rresp_ff;

endmodule

`default_nettype wire

// ===== tb/adc_config_serial_port_props.sv
// Port checker for the converter configuration block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module adc_cfg_props (
   // Clock and reset
   input wire logic        CLK, RST_N,
   // Bus handshakes
   input wire logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
   input wire logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY,
   input wire logic        S_AXI_RVALID, S_AXI_RREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic [31:0] S_AXI_RDATA,
   // Pins and decoded outputs
   input wire logic        RESET_PIN, MODE_PIN_1, MODE_PIN_2, MODE_PIN_3,
   input wire logic [1:0]  SELECT_LEVEL, SHIFT_CLK_LEVEL,
   input wire logic        PARALLEL_MODE, EXT_REF, TWOS_COMP, CMOS_OUT,
   input wire logic        POWER_DOWN, STANDBY_B, NOISE_SHAPE_ON_A, NOISE_SHAPE_ON_B
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   wire [2:0] mode = {MODE_PIN_1, MODE_PIN_2, MODE_PIN_3};
   ////////////////////////////////////////////////////////////////////////////////
   // Eight steady cycles cover the three-stage pin filter and the output register
   sequence s_mode_steady;
      $stable(mode)[*8];
   endsequence
   sequence s_par_steady;
      (RESET_PIN && PARALLEL_MODE && $stable({SELECT_LEVEL, SHIFT_CLK_LEVEL}))[*8];
   endsequence
   sequence s_wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   AST_MODE_PDOWN: assert property (s_mode_steady |-> POWER_DOWN == (mode == 3'h4))
      else $error("power down decode wrong");
   AST_MODE_STBY: assert property (s_mode_steady |-> STANDBY_B == (mode == 3'h5))
      else $error("standby decode wrong");
   AST_MODE_NS: assert property (s_mode_steady |->
      {NOISE_SHAPE_ON_A, NOISE_SHAPE_ON_B} == (mode[2] ? 2'h0 : mode[1:0]))
      else $error("noise shaping decode wrong");
   AST_PAR_REF: assert property (s_par_steady |->
      EXT_REF == (SHIFT_CLK_LEVEL inside {2'h1, 2'h2}))
      else $error("reference select wrong");
   AST_PAR_FMT: assert property (s_par_steady |->
      TWOS_COMP == (SELECT_LEVEL inside {2'h1, 2'h2}) && CMOS_OUT == SELECT_LEVEL[1])
      else $error("format select wrong");
   AST_SERIAL_QUIET: assert property ((!RESET_PIN)[*8] |->
      !PARALLEL_MODE && !EXT_REF && !TWOS_COMP && !CMOS_OUT)
      else $error("parallel outputs active with reset pin low");
   AST_PAR_ENTRY: assert property ($rose(PARALLEL_MODE) |-> $past(RESET_PIN, 40))
      else $error("parallel mode without held reset pin");
   AST_WR_ANSWER: assert property (s_wr_taken |-> ##[2:3] S_AXI_BVALID)
      else $error("write response late");
   AST_RD_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read response late");
   AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
endmodule
bind adc_config_serial_port adc_cfg_props props (.*);
`default_nettype wire

// ===== tb/cfg_serial_ctl.sv
// Model of the external configuration controller on the three-wire port.
// Assumes the bench calls its tasks; the shift clock idles high, 160 ns period.
`timescale 1ns/10ps
`default_nettype none
module cfg_serial_ctl (
   // Serial port pins
   output var logic sel_n,
   output var logic sclk,
   output var logic serial_data_in
);
   initial begin
      sel_n = 1'b1;
      sclk = 1'b1;
      serial_data_in = 1'b0;
   end
   // select low frames
   // Pins change after the bench's clock edge, never racing it
   task open;
      sel_n <= 1'b0;
      #80;
   endtask
   // Released data shows the inverse so a stale level is never trusted
   task close;
      #80;
      sel_n <= 1'b1;
      serial_data_in <= ~serial_data_in;
   endtask
   task park;
      serial_data_in <= 1'b0;
   endtask
   task bit_out(input logic b);
      serial_data_in <= b;
      #80;
      sclk <= 1'b0;
      #80;
      sclk <= 1'b1;
   endtask
   task word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) bit_out(w[i]);
   endtask
   task tail(input logic [3:0] t);
      for (int i = 3; i >= 0; i--) bit_out(t[i]);
   endtask
endmodule
`default_nettype wire

// ===== tb/adc_config_serial_port_test.sv
// Self-checking bench for the converter configuration block.
// Assumes the controller model drives the serial pins and the bench the rest.
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg_consts.vh"
module adc_config_serial_port_test;
   logic        CLK, RST_N, RESET_PIN, MODE_PIN_1, MODE_PIN_2, MODE_PIN_3;
   logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, rd;
   logic [3:0]  S_AXI_WSTRB;
   logic        S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
   logic [1:0]  SELECT_LEVEL, SHIFT_CLK_LEVEL, rsp;
   wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   wire  [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   wire  [31:0] S_AXI_RDATA;
   wire         SERIAL_SELECT_N, SHIFT_CLK, SERIAL_DATA_IN, PARALLEL_MODE, EXT_REF;
   wire         TWOS_COMP, CMOS_OUT, POWER_DOWN, STANDBY_B, NOISE_SHAPE_ON_A, NOISE_SHAPE_ON_B;
   int          fails = 0, n_tests = 0, cyc = 0;
   logic [6:0]  rows [8];

   adc_config_serial_port dut (.*);
   cfg_serial_ctl ctl (.sel_n(SERIAL_SELECT_N), .sclk(SHIFT_CLK), .serial_data_in(SERIAL_DATA_IN));

   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   // Whole run needs about 1100 cycles
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task results;
      $display("compared %0d, mismatched %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s: got %h want %h", $time, m, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge CLK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1);
      S_AXI_BREADY <= 1'b0;
      chk(S_AXI_BRESP, er, "write response");
   endtask
   task rdb(input logic [7:0] a);
      @(posedge CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge CLK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1);
      S_AXI_RREADY <= 1'b0;
      rd = S_AXI_RDATA;
      rsp = S_AXI_RRESP;
   endtask
   task bchk(input logic [7:0] i, input logic [7:0] v);
      wr(`OFS_INDEX, {24'h0, i}, `RESP_OKAY);
      rdb(`OFS_DATA);
      chk(rd, {24'h0, v}, "config byte");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      RST_N = 1'b0;
      RESET_PIN = 1'b0;
      {MODE_PIN_1, MODE_PIN_2, MODE_PIN_3} = 3'h0;
      {SELECT_LEVEL, SHIFT_CLK_LEVEL} = 4'h0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
      S_AXI_WSTRB = 4'hf;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
      // Mode pattern, then power down, standby, noise A, noise B
      rows = '{7'h00, 7'h11, 7'h22, 7'h33, 7'h48, 7'h54, 7'h60, 7'h70};
      repeat (16) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (2) @(posedge CLK);
      rdb(`OFS_CONTROL);
      chk(rd, 32'h1, "control reset");
      rdb(`OFS_WORDS);
      chk(rd, 32'h0, "word count reset");
      rdb(8'h14);
      chk(rsp, `RESP_SLVERR, "unmapped read");
      wr(8'h14, 32'h0, `RESP_SLVERR);
      $display("done: bus and reset values");
      for (int i = 0; i < 8; i++) begin
         {MODE_PIN_1, MODE_PIN_2, MODE_PIN_3} <= rows[i][6:4];
         repeat (10) @(posedge CLK);
         chk({POWER_DOWN, STANDBY_B, NOISE_SHAPE_ON_A, NOISE_SHAPE_ON_B}, rows[i][3:0], "mode");
         rdb(`OFS_STATUS);
         chk(rd[7:4], {rows[i][0], rows[i][1], rows[i][2], rows[i][3]}, "status mode");
      end
      {MODE_PIN_1, MODE_PIN_2, MODE_PIN_3} <= 3'h0;
      $display("done: mode pins");
      ctl.open();
      ctl.word(16'h215a);
      ctl.word(16'h42c3);
      ctl.tail(4'h2);
      ctl.close();
      repeat (8) @(posedge CLK);
      rdb(`OFS_WORDS);
      chk(rd, 32'h2, "words after frame");
      bchk(8'h21, 8'h5a);
      bchk(8'h42, 8'hc3);
      ctl.open();
      ctl.word(16'h0080);
      ctl.close();
      repeat (8) @(posedge CLK);
      bchk(8'h21, 8'h00);
      bchk(8'h00, 8'h00);
      $display("done: serial writes");
      ctl.open();
      ctl.word(16'h2177);
      ctl.close();
      repeat (8) @(posedge CLK);
      bchk(8'h21, 8'h77);
      // Port disabled: a full word must not land
      wr(`OFS_CONTROL, 32'h0, `RESP_OKAY);
      ctl.open();
      ctl.word(16'h2133);
      ctl.close();
      repeat (8) @(posedge CLK);
      bchk(8'h21, 8'h77);
      rdb(`OFS_CONTROL);
      chk(rd, 32'h0, "control disabled");
      wr(`OFS_CONTROL, 32'h1, `RESP_OKAY);
      RESET_PIN <= 1'b1;
      repeat (5) @(posedge CLK);
      RESET_PIN <= 1'b0;
      repeat (12) @(posedge CLK);
      bchk(8'h21, 8'h00);
      $display("done: reset pulse");
      ctl.park();
      RESET_PIN <= 1'b1;
      repeat (70) @(posedge CLK);
      chk(PARALLEL_MODE, 1'b1, "parallel entry");
      for (int l = 0; l < 4; l++) begin
         SHIFT_CLK_LEVEL <= l[1:0];
         SELECT_LEVEL <= l[1:0];
         repeat (10) @(posedge CLK);
         chk(EXT_REF, l == 1 || l == 2, "reference");
         chk({TWOS_COMP, CMOS_OUT}, {l == 1 || l == 2, l[1]}, "format");
      end
      rdb(`OFS_STATUS);
      chk(rd[3:0], 4'h9, "status parallel");
      RESET_PIN <= 1'b0;
      repeat (12) @(posedge CLK);
      chk({PARALLEL_MODE, CMOS_OUT}, 2'h0, "parallel exit");
      $display("done: parallel pins");
      results();
   end
endmodule
`default_nettype wire
